// ===== shared/pwm_pkg.sv
// register map, field positions and codes of the 11-bit pwm block
// assumes an 8-bit io space with 6-bit addresses
package pwm_pkg;
   localparam int ADDR_W = 6;
   localparam logic [5:0] PWM1_DUTY_HIGH_OFS = 6'h28;
   localparam logic [5:0] PWM1_DUTY_LOW_OFS = 6'h29;
   localparam logic [5:0] PWM1_BOUND_HIGH_OFS = 6'h2a;
   localparam logic [5:0] PWM1_BOUND_LOW_OFS = 6'h2b;
   localparam logic [5:0] PWM2_CONTROL_OFS = 6'h2c;
   localparam logic [5:0] PWM2_SCALER_OFS = 6'h2d;
   localparam logic [5:0] PWM2_DUTY_HIGH_OFS = 6'h2e;
   localparam logic [5:0] PWM2_DUTY_LOW_OFS = 6'h2f;
   localparam logic [5:0] PWM2_BOUND_HIGH_OFS = 6'h30;
   localparam logic [5:0] PWM2_BOUND_LOW_OFS = 6'h31;
   // control fields
   localparam int CTL_ENABLE_BIT = 7;
   localparam int CTL_LEVEL_BIT = 6;
   localparam int CTL_INVERT_BIT = 5;
   localparam int CTL_CLEAR_BIT = 4;
   localparam int CTL_ROUTE_MSB = 3;
   localparam int CTL_ROUTE_LSB = 1;
   localparam int CTL_SOURCE_BIT = 0;
   localparam logic [7:0] CONTROL_RESET = 8'h00;
   // scaler fields
   localparam int SCL_MODE_BIT = 7;
   localparam int SCL_PRE_MSB = 6;
   localparam int SCL_PRE_LSB = 5;
   localparam int SCL_DIV_MSB = 4;
   localparam logic [7:0] SCALER_RESET = 8'h00;
   // low registers hold value bits 2..0 in 7..5
   localparam int LOW_FIELD_MSB = 7;
   localparam int LOW_FIELD_LSB = 5;
   localparam logic [10:0] VALUE_RESET = 11'h000;
   // output routing codes
   localparam logic [2:0] ROUTE_NONE = 3'h0;
   localparam logic [2:0] ROUTE_B3 = 3'h1;
   localparam logic [2:0] ROUTE_A3 = 3'h3;
   localparam logic [2:0] ROUTE_B2 = 3'h4;
   localparam logic [2:0] ROUTE_A5 = 3'h5;
   // prescale ratios 1, 4, 16, 64, stored as terminal counts
   localparam logic [5:0] PRE_LAST_1 = 6'h00;
   localparam logic [5:0] PRE_LAST_4 = 6'h03;
   localparam logic [5:0] PRE_LAST_16 = 6'h0f;
   localparam logic [5:0] PRE_LAST_64 = 6'h3f;
endpackage

// ===== shared/pwm_tick_if.sv
// carries the clock-shaping settings to the prescaler and its tick back
// both ends run on the block clock
`timescale 1ns/100ps
interface pwm_tick_if;
   logic src_tick;
   logic run;
   logic [1:0] pre_sel;
   logic [4:0] divider;
   logic count_tick;
   modport ctrl (output src_tick, output run, output pre_sel, output divider, input count_tick);
   modport scaler (input src_tick, input run, input pre_sel, input divider, output count_tick);
endinterface

// ===== hw/pwm_prescaler.sv
// prescaler (1/4/16/64) followed by a divide-by-(n+1) stage
// src_tick is a one-cycle enable from the chosen clock source
`timescale 1ns/100ps
module pwm_prescaler
   import pwm_pkg::*;
(
   input wire logic clk_i,
   input wire logic rstn_i,
   pwm_tick_if.scaler tk
);
   typedef struct packed {
      logic [5:0] pre_cnt;
      logic [4:0] div_cnt;
      logic tick;
   } scale_state_t;
   scale_state_t s_q, s_d;
   logic [5:0] pre_last;

   always_comb begin
      unique case (tk.pre_sel)
         2'h0: pre_last = PRE_LAST_1;
         2'h1: pre_last = PRE_LAST_4;
         2'h2: pre_last = PRE_LAST_16;
         2'h3: pre_last = PRE_LAST_64;
      endcase
   end

   always_comb begin
      s_d = s_q;
      s_d.tick = 1'b0;
      if (!tk.run) begin
         s_d.pre_cnt = 6'h00;
         s_d.div_cnt = 5'h00;
      end else if (tk.src_tick) begin
         if (s_q.pre_cnt >= pre_last) begin
            s_d.pre_cnt = 6'h00;
            if (s_q.div_cnt >= tk.divider) begin
               s_d.div_cnt = 5'h00;
               s_d.tick = 1'b1;
            end else begin
               s_d.div_cnt = s_q.div_cnt + 5'h01;
            end
         end else begin
            s_d.pre_cnt = s_q.pre_cnt + 6'h01;
         end
      end
   end

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign tk.count_tick = s_q.tick;
endmodule // pwm_prescaler

// ===== hw/pwm_generator.sv
// 11-bit pwm: second unit complete, first unit bound and duty holding registers
// assumes io strobes are one-cycle pulses synchronous to clk_i
// assumes the fast oscillator arrives as a synchronous one-cycle tick
`timescale 1ns/100ps
module pwm_generator
   import pwm_pkg::*;
#(
   parameter int CNT_W = 11
)(
   input wire logic clk_i,
   input wire logic rstn_i,
   input wire logic [5:0] io_addr_i,
   input wire logic io_wr_i,
   input wire logic [7:0] io_wdata_i,
   input wire logic io_rd_i,
   output logic [7:0] io_rdata_o,
   input wire logic fast_rc_tick_i,
   output logic [10:0] pwm1_bound_o,
   output logic [10:0] pwm1_duty_o,
   output logic pwm2_event_o,
   output logic port_b_line_3_o,
   output logic port_b_line_3_en_o,
   output logic port_a_line_3_o,
   output logic port_a_line_3_en_o,
   output logic port_b_line_2_o,
   output logic port_b_line_2_en_o,
   output logic port_a_line_5_o,
   output logic port_a_line_5_en_o
);
   // the split registers and the compares are sized for 11 bits only
   if (CNT_W != 11) begin : g_width_check
      $error("pwm_generator supports an 11-bit counter only");
   end
   // each low register carries exactly the three low value bits
   if (LOW_FIELD_MSB - LOW_FIELD_LSB != 2) begin : g_low_check
      $error("pwm_generator expects a 3-bit low field");
   end
   // the route field must hold the 3-bit pin codes
   if (CTL_ROUTE_MSB - CTL_ROUTE_LSB != 2) begin : g_route_check
      $error("pwm_generator expects a 3-bit route field");
   end

   typedef struct packed {
      logic enable;
      logic invert;
      logic clear;
      logic [2:0] route;
      logic source;
      logic event_on_duty;
      logic [1:0] pre_sel;
      logic [4:0] divider;
      logic [10:0] bound2;
      logic [10:0] duty2;
      logic [2:0] duty2_low;
      logic [10:0] bound1;
      logic [10:0] duty1;
      logic [2:0] duty1_low;
      logic [10:0] count;
      logic level;
      logic evt;
      logic [7:0] rdata;
   } pwm_state_t;

   pwm_state_t s_q, s_d;
   pwm_tick_if tk ();

   ////////////////////////////////////////////////////////////////////////////
   // clock source and prescaler

   assign tk.src_tick = s_q.source ? fast_rc_tick_i : 1'b1;
   // run drops during a clear so the prescaler restarts together with the counter
   assign tk.run = s_q.enable && !s_q.clear;
   assign tk.pre_sel = s_q.pre_sel;
   assign tk.divider = s_q.divider;

   pwm_prescaler u_prescaler (
      .clk_i(clk_i),
      .rstn_i(rstn_i),
      .tk(tk)
   );

   ////////////////////////////////////////////////////////////////////////////
   // registers and counter

   logic wr_hit;
   logic rd_ctl;
   logic [2:0] low_field;
   logic raw_level;
   logic at_bound;
   logic evt_hit;
   logic [7:0] ctl_view;

   always_comb begin
      wr_hit = io_wr_i;
      rd_ctl = io_rd_i && (io_addr_i == PWM2_CONTROL_OFS);
      // low registers keep bits 7..5 only; the reserved bits are dropped
      low_field = io_wdata_i[LOW_FIELD_MSB:LOW_FIELD_LSB];
      raw_level = (s_q.count < s_q.duty2);
      // >= not ==: a bound lowered under the count wraps at once, not after 2048 ticks
      at_bound = (s_q.count >= s_q.bound2);
      // event point follows the scaler mode bit
      if (s_q.event_on_duty) begin
         evt_hit = (s_q.count == s_q.duty2);
      end else begin
         evt_hit = (s_q.count == VALUE_RESET);
      end
      ctl_view = {s_q.enable, s_q.level, s_q.invert, s_q.clear, s_q.route, s_q.source};
   end

   always_comb begin
      s_d = s_q;
      s_d.evt = 1'b0;

      // counter: clear request wins over counting
      if (s_q.clear) begin
         s_d.count = VALUE_RESET;
         s_d.clear = 1'b0;
      end else if (!s_q.enable) begin
         s_d.count = VALUE_RESET;
      end else if (tk.count_tick) begin
         if (at_bound) begin
            s_d.count = VALUE_RESET;
         end else begin
            s_d.count = s_q.count + 11'h001;
         end
         s_d.evt = evt_hit;
      end

      // output held low while stopped, then polarity applied
      // bit 6 and the pins both report the level after inversion
      s_d.level = (s_q.enable && raw_level) ^ s_q.invert;

      if (wr_hit) begin
         unique case (io_addr_i)
            PWM2_CONTROL_OFS: begin
               s_d.enable = io_wdata_i[CTL_ENABLE_BIT];
               s_d.invert = io_wdata_i[CTL_INVERT_BIT];
               s_d.clear = io_wdata_i[CTL_CLEAR_BIT];
               s_d.route = io_wdata_i[CTL_ROUTE_MSB:CTL_ROUTE_LSB];
               s_d.source = io_wdata_i[CTL_SOURCE_BIT];
            end
            PWM2_SCALER_OFS: begin
               s_d.event_on_duty = io_wdata_i[SCL_MODE_BIT];
               s_d.pre_sel = io_wdata_i[SCL_PRE_MSB:SCL_PRE_LSB];
               s_d.divider = io_wdata_i[SCL_DIV_MSB:0];
            end
            PWM2_BOUND_HIGH_OFS: begin
               // halves apply on their own writes, so a bound change may give one odd period
               s_d.bound2[10:3] = io_wdata_i;
            end
            PWM2_BOUND_LOW_OFS: s_d.bound2[2:0] = low_field;
            PWM2_DUTY_LOW_OFS: s_d.duty2_low = low_field;
            PWM2_DUTY_HIGH_OFS: begin
               // both halves land together, so the compare never sees a mixed duty
               s_d.duty2 = {io_wdata_i, s_q.duty2_low};
            end
            PWM1_BOUND_HIGH_OFS: begin
               // first unit values are only held and exported; its counter lives elsewhere
               s_d.bound1[10:3] = io_wdata_i;
            end
            PWM1_BOUND_LOW_OFS: s_d.bound1[2:0] = low_field;
            PWM1_DUTY_LOW_OFS: s_d.duty1_low = low_field;
            PWM1_DUTY_HIGH_OFS: begin
               // same pairing as the second unit
               s_d.duty1 = {io_wdata_i, s_q.duty1_low};
            end
            default: ;
         endcase
      end

      // only control reads back; write-only registers answer zero
      s_d.rdata = 8'h00;
      if (rd_ctl) begin
         s_d.rdata = ctl_view;
      end
   end

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // pin routing; reserved codes match no entry and drive nothing

   // pin order: port b line 3, port a line 3, port b line 2, port a line 5
   localparam logic [3:0][2:0] PIN_CODE = {ROUTE_A5, ROUTE_B2, ROUTE_A3, ROUTE_B3};
   wire logic [3:0] pin_en;
   wire logic [3:0] pin_dat;

   for (genvar p = 0; p < 4; p++) begin : g_pin
      assign pin_en[p] = (s_q.route == PIN_CODE[p]);
      // unrouted pins sit low so the load sees its pull-down, not a stale level
      assign pin_dat[p] = pin_en[p] & s_q.level;
   end

   assign port_b_line_3_en_o = pin_en[0];
   assign port_a_line_3_en_o = pin_en[1];
   assign port_b_line_2_en_o = pin_en[2];
   assign port_a_line_5_en_o = pin_en[3];
   assign port_b_line_3_o = pin_dat[0];
   assign port_a_line_3_o = pin_dat[1];
   assign port_b_line_2_o = pin_dat[2];
   assign port_a_line_5_o = pin_dat[3];

   assign io_rdata_o = s_q.rdata;
   assign pwm1_bound_o = s_q.bound1;
   assign pwm1_duty_o = s_q.duty1;
   assign pwm2_event_o = s_q.evt;
endmodule // pwm_generator

// ===== testbench/pwm_pin_load.sv
// external load on the four selectable pins
// undriven pins fall to the pull-down level
`timescale 1ns/100ps
module pwm_pin_load (
   input wire logic [3:0] drive_i,
   input wire logic [3:0] en_i,
   output logic [3:0] pin_o
);
   assign pin_o = drive_i & en_i;
endmodule // pwm_pin_load

// ===== testbench/pwm_generator_props.sv
// port checker for pwm_generator
// bound to every instance, single clock domain
`timescale 1ns/100ps
module pwm_checker
   import pwm_pkg::*;
#(
   parameter int CNT_W = 11
)(
   input wire logic clk_i,
   input wire logic rstn_i,
   input wire logic [5:0] io_addr_i,
   input wire logic io_wr_i,
   input wire logic [7:0] io_wdata_i,
   input wire logic io_rd_i,
   input wire logic [7:0] io_rdata_o,
   input wire logic [10:0] pwm1_bound_o,
   input wire logic [10:0] pwm1_duty_o,
   input wire logic [3:0] dat,
   input wire logic [3:0] en
);
   wire logic w_ctl = io_wr_i && io_addr_i == PWM2_CONTROL_OFS;
   wire logic w_dh = io_wr_i && io_addr_i == PWM1_DUTY_HIGH_OFS;
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rstn_i);
   AST_RD_IDLE: assert property (!io_rd_i |=> io_rdata_o == 8'h00) else $error("rdata not idle");
   AST_RD_WO: assert property (io_rd_i && io_addr_i != PWM2_CONTROL_OFS |=> io_rdata_o == 8'h00)
      else $error("write-only read back");
   AST_ONE_PIN: assert property ($onehot0(en)) else $error("two pins routed");
   AST_GATE: assert property ((dat & ~en) == 4'h0) else $error("unrouted pin driven");
   AST_ROUTE_OFF: assert property (w_ctl && io_wdata_i[3:1] == ROUTE_NONE |=> ##[0:1] en == 4'h0)
      else $error("route none left a pin");
   AST_ROUTE_A5: assert property (w_ctl && io_wdata_i[3:1] == ROUTE_A5 |=> ##[0:1] en == 4'h8)
      else $error("route a5 missing");
   AST_DUTY1: assert property (w_dh |=> pwm1_duty_o[10:3] == $past(io_wdata_i))
      else $error("duty high not taken");
   AST_DUTY1_HOLD: assert property (!w_dh |=> $stable(pwm1_duty_o)) else $error("duty moved early");
   AST_BOUND1: assert property (io_wr_i && io_addr_i == PWM1_BOUND_LOW_OFS
      |=> pwm1_bound_o[2:0] == $past(io_wdata_i[7:5])) else $error("bound low not taken");
   cover property (w_ctl && io_wdata_i[7]);
   cover property (w_dh);
   cover property (io_rd_i && io_addr_i == PWM2_CONTROL_OFS);
endmodule // pwm_checker
bind pwm_generator pwm_checker #(.CNT_W(CNT_W)) pwm_checker_inst (.clk_i(clk_i), .rstn_i(rstn_i),
   .io_addr_i(io_addr_i), .io_wr_i(io_wr_i), .io_wdata_i(io_wdata_i), .io_rd_i(io_rd_i), .io_rdata_o(io_rdata_o),
   .pwm1_bound_o(pwm1_bound_o), .pwm1_duty_o(pwm1_duty_o),
   .dat({port_a_line_5_o, port_b_line_2_o, port_a_line_3_o, port_b_line_3_o}),
   .en({port_a_line_5_en_o, port_b_line_2_en_o, port_a_line_3_en_o, port_b_line_3_en_o}));

// ===== testbench/test_pwm_generator.sv
// self-checking bench for pwm_generator
// 40 MHz clock, pins loaded by pwm_pin_load
`timescale 1ns/100ps
module test_pwm_generator;
   import pwm_pkg::*;
   logic clk_i = 1'b0;
   logic rstn_i = 1'b0;
   logic [5:0] io_addr_i = 6'h00;
   logic io_wr_i = 1'b0;
   logic [7:0] io_wdata_i = 8'h00;
   logic io_rd_i = 1'b0;
   logic fast_rc_tick_i = 1'b0;
   logic [7:0] io_rdata_o;
   logic [10:0] pwm1_bound_o, pwm1_duty_o, v;
   logic pwm2_event_o;
   logic rd_seen = 1'b0;
   logic [3:0] dat, en, pin;
   logic [7:0] rd_q[$];
   int errors = 0, n_tests = 0, rc_cnt = 0, hi, ev;
   // bound 4 and duty 2: per 960 cycles the high and event counts are exact for every prescale
   logic [7:0] ctl_t [7] = '{8'h92, 8'h96, 8'h98, 8'hba, 8'h93, 8'h9a, 8'h92};
   logic [7:0] scl_t [7] = '{8'h00, 8'h20, 8'h81, 8'h00, 8'h00, 8'hc0, 8'h60};
   int hi_t [7] = '{384, 384, 384, 576, 384, 384, 384};
   int ev_t [7] = '{192, 48, 96, 192, 64, 12, 3};
   int pin_t [7] = '{0, 1, 2, 3, 0, 3, 0};
   pwm_generator pwm_generator_inst (.clk_i(clk_i), .rstn_i(rstn_i), .io_addr_i(io_addr_i), .io_wr_i(io_wr_i),
      .io_wdata_i(io_wdata_i), .io_rd_i(io_rd_i), .io_rdata_o(io_rdata_o), .fast_rc_tick_i(fast_rc_tick_i),
      .pwm1_bound_o(pwm1_bound_o), .pwm1_duty_o(pwm1_duty_o), .pwm2_event_o(pwm2_event_o),
      .port_b_line_3_o(dat[0]), .port_b_line_3_en_o(en[0]), .port_a_line_3_o(dat[1]), .port_a_line_3_en_o(en[1]),
      .port_b_line_2_o(dat[2]), .port_b_line_2_en_o(en[2]), .port_a_line_5_o(dat[3]), .port_a_line_5_en_o(en[3]));
   pwm_pin_load pwm_pin_load_inst (.drive_i(dat), .en_i(en), .pin_o(pin));
   always #12.5 clk_i = ~clk_i;
   ////////////////////////////////////////////////////////////////
   task automatic cmp(input logic [10:0] got, input logic [10:0] exp);
      n_tests++;
      if (got !== exp) begin
         errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // rd=1: d is the expected read data
   task automatic io(input logic rd, input logic [5:0] a, input logic [7:0] d);
      @(posedge clk_i);
      #2;
      io_addr_i = a;
      io_wdata_i = d;
      io_rd_i = rd;
      io_wr_i = !rd;
      if (rd) rd_q.push_back(d);
      @(posedge clk_i);
      #2;
      io_rd_i = 1'b0;
      io_wr_i = 1'b0;
   endtask
   task automatic end_sim();
      $display("errors=%0d n_tests=%0d", errors, n_tests);
      if (errors == 0 && n_tests > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////
   always @(posedge clk_i) begin
      if (rd_seen) cmp({3'h0, io_rdata_o}, {3'h0, rd_q.pop_front()});
      rd_seen <= io_rd_i;
   end
   // fast oscillator edge every third cycle, unrelated to the counter phase
   always @(posedge clk_i) begin
      #2;
      rc_cnt = (rc_cnt + 1) % 3;
      fast_rc_tick_i = (rc_cnt == 0);
   end
   initial begin
      #400000;
      errors++;
      end_sim();
   end
   initial begin
      void'($urandom(32'h2f460bdd));
      repeat (8) @(posedge clk_i);
      #2 rstn_i = 1'b1;
      io(1, PWM2_CONTROL_OFS, CONTROL_RESET);
      cmp(pwm1_duty_o | pwm1_bound_o, VALUE_RESET);
      for (int k = 0; k < 3; k++) begin
         v = 11'($urandom);
         io(0, PWM1_DUTY_LOW_OFS, {v[2:0], 5'h00});
         io(0, PWM1_DUTY_HIGH_OFS, v[10:3]);
         io(0, PWM1_BOUND_HIGH_OFS, ~v[10:3]);
         io(0, PWM1_BOUND_LOW_OFS, {~v[2:0], 5'h1f});
         cmp(pwm1_duty_o, v);
         cmp(pwm1_bound_o, ~v);
      end
      io(1, PWM1_DUTY_HIGH_OFS, 8'h00);
      io(1, 6'h3f, 8'h00);
      io(0, PWM2_CONTROL_OFS, 8'h30);
      repeat (3) @(posedge clk_i);
      io(1, PWM2_CONTROL_OFS, 8'h60);
      io(0, PWM2_BOUND_HIGH_OFS, 8'h00);
      io(0, PWM2_BOUND_LOW_OFS, 8'h80);
      io(0, PWM2_DUTY_LOW_OFS, 8'h40);
      io(0, PWM2_DUTY_HIGH_OFS, 8'h00);
      for (int i = 0; i < 7; i++) begin
         io(0, PWM2_SCALER_OFS, scl_t[i]);
         io(0, PWM2_CONTROL_OFS, ctl_t[i]);
         repeat (30) @(posedge clk_i);
         hi = 0;
         ev = 0;
         repeat (960) begin
            @(posedge clk_i);
            #2;
            hi += (pin[pin_t[i]] === 1'b1);
            ev += (pwm2_event_o === 1'b1);
         end
         cmp({7'h0, en}, 11'(1 << pin_t[i]));
         cmp(11'(hi), 11'(hi_t[i]));
         cmp(11'(ev), 11'(ev_t[i]));
      end
      io(0, PWM2_CONTROL_OFS, 8'h84);
      repeat (2) @(posedge clk_i);
      cmp({7'h0, en}, 11'h000);
      io(0, PWM2_CONTROL_OFS, 8'h80);
      repeat (2) @(posedge clk_i);
      cmp({7'h0, en}, 11'h000);
      end_sim();
   end
endmodule // test_pwm_generator
